//--- rtl/wdg_consts.svh
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH
// =====================================================================
// register byte offsets
`define WDG_OFS_RESET_STATUS   12'h000
`define WDG_OFS_OPTIONS_FIRST  12'h004
`define WDG_OFS_OPTIONS_SECOND 12'h008
`define WDG_OFS_COUNT          12'h00C
// =====================================================================
// field positions
`define WDG_BIT_ENABLE         7
`define WDG_BIT_TIMEOUT_SEL    6
`define WDG_BIT_CLOCK_SEL      7
`define WDG_BIT_SRC_WATCHDOG   5
`define WDG_BIT_SRC_POWER_ON   7
// =====================================================================
// reset values
`define WDG_RST_ENABLE         1'b1
`define WDG_RST_TIMEOUT_SEL    1'b1
`define WDG_RST_CLOCK_SEL      1'b0
// =====================================================================
// overflow exponents
`define WDG_EXP_SLOW_SHORT     5
`define WDG_EXP_SLOW_LONG      8
`define WDG_EXP_BUS_SHORT      13
`define WDG_EXP_BUS_LONG       18
// =====================================================================
// timing
`define WDG_CLK_PERIOD_NS      40
`define WDG_LOW_FREQ_PERIOD_NS 1000000
`define WDG_LOW_FREQ_CYCLES    (`WDG_LOW_FREQ_PERIOD_NS / `WDG_CLK_PERIOD_NS)
`define WDG_RESET_PULSE_CYCLES 16
`endif

//--- rtl/wdg_counter.sv
`timescale 1ns/10ps
`include "wdg_consts.svh"
module wdg_counter (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire wdg_pkg::wdg_cfg_t cfg,
  input  wire logic          service,
  input  wire logic          slowTick,
  input  wire logic          stopMode,
  input  wire logic          debugMode,
  output logic [17:0]        count_q,
  output logic               overflow
);
  function automatic logic [17:0] limitOf(input wdg_pkg::wdg_cfg_t c);
    int e;
    e = c.clockSel ? (c.timeoutSel ? `WDG_EXP_BUS_LONG : `WDG_EXP_BUS_SHORT)
                   : (c.timeoutSel ? `WDG_EXP_SLOW_LONG : `WDG_EXP_SLOW_SHORT);
    return 18'((64'h1 << e) - 64'h1);
  endfunction

  wire       srcTick  = cfg.clockSel ? 1'b1 : slowTick;
  wire       slowStop = stopMode && !cfg.clockSel;
  wire       advance  = cfg.enable && srcTick && !stopMode && !debugMode;
  wire       atLimit  = (count_q == limitOf(cfg));

  assign overflow = advance && atLimit && !service;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_q <= 18'h00000;
    end else if (service || slowStop || !cfg.enable) begin
      count_q <= 18'h00000;
    end else if (advance) begin
      count_q <= atLimit ? 18'h00000 : count_q + 18'h00001;
    end
  end
endmodule

//--- rtl/wdg_pkg.sv
package wdg_pkg;
  typedef struct packed {
    logic enable;
    logic clockSel;
    logic timeoutSel;
  } wdg_cfg_t;

  typedef enum logic [1:0] {
    WDG_BUS_IDLE = 2'b00,
    WDG_BUS_RESP = 2'b01
  } wdg_wstate_t;
endpackage

//--- rtl/wdg_tick_gen.sv
`timescale 1ns/10ps
`include "wdg_consts.svh"
module wdg_tick_gen #(
  parameter int DIVIDE = `WDG_LOW_FREQ_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] divCnt_q;
  wire         divEnd = (divCnt_q == 32'(DIVIDE - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= 32'h0000_0000;
      tick     <= 1'b0;
    end else begin
      divCnt_q <= (restart || divEnd) ? 32'h0000_0000 : divCnt_q + 32'h0000_0001;
      tick     <= divEnd && !restart;
    end
  end
endmodule

//--- rtl/wdg_top.sv
// What this block does
// - overflow before service forces system reset
// - reset sets enable; clearing disables watchdog
// - any write to status address clears counter
// - clock select: 0 slow, 1 bus
// - slow source: 2^5 or 2^8 cycles
// - bus source: 2^13 or 2^18 cycles
// - default is slow source, long timeout
// - option registers accept first write only
// - first option writes clear the counter
// - debug mode holds the counter
// - bus source: stop freezes, then resumes
// - slow source: stop clears counter to zero
// - slow clock period nominally one millisecond
// - watchdog reset recorded in status register
`timescale 1ns/10ps
`include "wdg_consts.svh"
module wdg_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        powerOnReset,
  input  wire logic        stopMode,
  input  wire logic        debugMode,
  output logic             systemResetReq,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ===================================================================
  // write channel
  logic [11:0]       awAddr_q;
  logic              awHeld_q;
  logic [31:0]       wData_q;
  logic              wHeld_q;
  wdg_pkg::wdg_cfg_t cfg_q;
  logic              firstLocked_q;
  logic              secondLocked_q;
  logic              srcWatchdog_q;
  logic              srcPowerOn_q;
  logic [7:0]        pulseCnt_q;
  logic              wdgReset_q;
  logic [17:0]       count;
  logic              overflow;
  logic              slowTick;

  wire        awTake    = s_axi_awvalid && s_axi_awready;
  wire        wTake     = s_axi_wvalid && s_axi_wready;
  wire        haveAw    = awHeld_q || awTake;
  wire        haveW     = wHeld_q || wTake;
  wire [11:0] wAddr     = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wData     = wHeld_q ? wData_q : s_axi_wdata;
  wire        wrFire    = haveAw && haveW && !s_axi_bvalid;
  wire        wrStatus  = wrFire && (wAddr == `WDG_OFS_RESET_STATUS);
  wire        wrFirst   = wrFire && (wAddr == `WDG_OFS_OPTIONS_FIRST) && !firstLocked_q;
  wire        wrSecond  = wrFire && (wAddr == `WDG_OFS_OPTIONS_SECOND) && !secondLocked_q;
  wire        wrMapped  = (wAddr[11:4] == 8'h00);
  wire        service   = wrStatus || wrFirst || wrSecond;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 12'h000;
      wData_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (awTake) awAddr_q <= s_axi_awaddr;
      if (wTake) wData_q <= s_axi_wdata;
      if (wrFire) begin
        awHeld_q      <= 1'b0;
        wHeld_q       <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrMapped ? 2'b00 : 2'b10;
      end else begin
        if (awTake) begin
          awHeld_q      <= 1'b1;
          s_axi_awready <= 1'b0;
        end
        if (wTake) begin
          wHeld_q      <= 1'b1;
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid  <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready  <= 1'b1;
        end
      end
    end
  end

  // ===================================================================
  // write-once options
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q.enable     <= `WDG_RST_ENABLE;
      cfg_q.timeoutSel <= `WDG_RST_TIMEOUT_SEL;
      cfg_q.clockSel   <= `WDG_RST_CLOCK_SEL;
      firstLocked_q    <= 1'b0;
      secondLocked_q   <= 1'b0;
    end else begin
      if (wrFirst) begin
        cfg_q.enable     <= wData[`WDG_BIT_ENABLE];
        cfg_q.timeoutSel <= wData[`WDG_BIT_TIMEOUT_SEL];
        firstLocked_q    <= 1'b1;
      end
      if (wrSecond) begin
        cfg_q.clockSel <= wData[`WDG_BIT_CLOCK_SEL];
        secondLocked_q <= 1'b1;
      end
    end
  end

  // ===================================================================
  // counter and timebase
  wdg_tick_gen u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .restart (stopMode),
    .tick    (slowTick)
  );

  wdg_counter u_count (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .cfg       (cfg_q),
    .service   (service),
    .slowTick  (slowTick),
    .stopMode  (stopMode),
    .debugMode (debugMode),
    .count_q   (count),
    .overflow  (overflow)
  );

  // ===================================================================
  // reset request and cause record
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulseCnt_q     <= 8'h00;
      wdgReset_q     <= 1'b0;
      systemResetReq <= 1'b0;
    end else begin
      if (overflow) begin
        pulseCnt_q <= 8'(`WDG_RESET_PULSE_CYCLES);
        wdgReset_q <= 1'b1;
      end else if (pulseCnt_q != 8'h00) begin
        pulseCnt_q <= pulseCnt_q - 8'h01;
      end
      systemResetReq <= overflow || (pulseCnt_q > 8'h01);
    end
  end

  // power-on marks its own cause and clears the watchdog cause
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      srcWatchdog_q <= 1'b0;
      srcPowerOn_q  <= 1'b0;
    end else if (powerOnReset) begin
      srcWatchdog_q <= 1'b0;
      srcPowerOn_q  <= 1'b1;
    end else if (overflow) begin
      srcWatchdog_q <= 1'b1;
      srcPowerOn_q  <= 1'b0;
    end
  end

  // ===================================================================
  // read channel
  logic [31:0] rdMux;
  wire [11:0]  rAddr = s_axi_araddr;
  wire         arTake = s_axi_arvalid && s_axi_arready;
  wire         rMapped = (rAddr[11:4] == 8'h00);

  always_comb begin
    rdMux = 32'h0000_0000;
    case (rAddr)
      `WDG_OFS_RESET_STATUS: begin
        rdMux[`WDG_BIT_SRC_WATCHDOG] = srcWatchdog_q;
        rdMux[`WDG_BIT_SRC_POWER_ON] = srcPowerOn_q;
      end
      `WDG_OFS_OPTIONS_FIRST: begin
        rdMux[`WDG_BIT_ENABLE]      = cfg_q.enable;
        rdMux[`WDG_BIT_TIMEOUT_SEL] = cfg_q.timeoutSel;
      end
      `WDG_OFS_OPTIONS_SECOND: begin
        rdMux[`WDG_BIT_CLOCK_SEL] = cfg_q.clockSel;
      end
      `WDG_OFS_COUNT: begin
        rdMux[17:0] = count;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rMapped ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

//--- sim/test_wdg_top.sv
`timescale 1ns/10ps
module test_wdg_top;
  logic        clk_sys, resetn, powerOnReset, stopMode, debugMode, systemResetReq;
  logic        awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0]  bResp, rResp;
  logic [33:0] qB[$], qR[$];
  int          n_errors, checks_done, n, t;

  wdg_top uut (
    .clk_sys(clk_sys), .resetn(resetn), .powerOnReset(powerOnReset), .stopMode(stopMode),
    .debugMode(debugMode), .systemResetReq(systemResetReq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady)
  );

  always #20 clk_sys = ~clk_sys;

  // =====================================================
  // compare, bus access, closing
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    @(posedge clk_sys);
    if (w) qB.push_back(e);
    else qR.push_back(e);
    awAddr  <= a;
    arAddr  <= a;
    wData   <= d;
    awValid <= w;
    wValid  <= w;
    bReady  <= w;
    arValid <= !w;
    rReady  <= !w;
    do begin
      @(posedge clk_sys);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (arReady) arValid <= 1'b0;
    end while (w ? !bValid : !rValid);
    bReady <= 1'b0;
    rReady <= 1'b0;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // responses checked against the oldest note
  always @(posedge clk_sys) begin
    if (bValid && bReady && qB.size() > 0) chk({bResp, 32'h0}, qB.pop_front());
    if (rValid && rReady && qR.size() > 0) chk({rResp, rData}, qR.pop_front());
  end

  initial begin
    #2400000;
    n_errors++;
    end_sim();
  end

  // =====================================================
  // scenarios
  initial begin
    {clk_sys, resetn, powerOnReset, stopMode, debugMode} = 5'h00;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    {awAddr, arAddr, wData} = 56'h0;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(452));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    debugMode <= 1'b1;
    acc(1'b0, 12'h004, 32'h0, 34'h0C0);
    acc(1'b0, 12'h008, 32'h0, 34'h000);
    acc(1'b0, 12'h00C, 32'h0, 34'h000);
    $display("defaults done");
    acc(1'b1, 12'h008, 32'h80, 34'h0);
    debugMode <= 1'b0;
    repeat (5) @(posedge clk_sys);
    debugMode <= 1'b1;
    acc(1'b0, 12'h00C, 32'h0, 34'h5);
    acc(1'b1, 12'h004, 32'h80, 34'h0);
    acc(1'b0, 12'h00C, 32'h0, 34'h0);
    acc(1'b1, 12'h004, 32'h40, 34'h0);
    acc(1'b1, 12'h008, 32'h00, 34'h0);
    acc(1'b0, 12'h004, 32'h0, 34'h080);
    acc(1'b0, 12'h008, 32'h0, 34'h080);
    $display("lock done");
    n = $urandom_range(200, 20);
    debugMode <= 1'b0;
    repeat (n) @(posedge clk_sys);
    stopMode <= 1'b1;
    repeat (30) @(posedge clk_sys);
    acc(1'b0, 12'h00C, 32'h0, {2'b00, 32'(n)});
    acc(1'b1, 12'h000, $urandom, 34'h0);
    acc(1'b0, 12'h00C, 32'h0, 34'h0);
    acc(1'b0, 12'h000, 32'h0, 34'h0);
    $display("freeze done");
    stopMode <= 1'b0;
    t = 0;
    while (!systemResetReq && t < 9000) begin
      @(posedge clk_sys);
      t++;
    end
    chk({33'h0, t >= 8190 && t <= 8196}, 34'h1);
    t = 0;
    while (systemResetReq && t < 40) begin
      @(posedge clk_sys);
      t++;
    end
    chk(34'(t), 34'h10);
    acc(1'b0, 12'h000, 32'h0, 34'h020);
    debugMode <= 1'b1;
    acc(1'b1, 12'h000, $urandom, 34'h0);
    acc(1'b0, 12'h000, 32'h0, 34'h020);
    acc(1'b0, 12'h010, 32'h0, {2'b10, 32'h0});
    acc(1'b1, 12'h0F0, $urandom, {2'b10, 32'h0});
    powerOnReset <= 1'b1;
    @(posedge clk_sys);
    powerOnReset <= 1'b0;
    acc(1'b0, 12'h000, 32'h0, 34'h080);
    $display("overflow done");
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    debugMode <= 1'b0;
    acc(1'b1, 12'h004, 32'h00, 34'h0);
    acc(1'b1, 12'h008, 32'h80, 34'h0);
    repeat (200) @(posedge clk_sys);
    acc(1'b0, 12'h00C, 32'h0, 34'h0);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (25100) @(posedge clk_sys);
    acc(1'b0, 12'h00C, 32'h0, 34'h1);
    stopMode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 12'h00C, 32'h0, 34'h0);
    $display("slow source done");
    end_sim();
  end
endmodule

//--- sim/wdg_monitor.sv
`timescale 1ns/10ps
module wdg_monitor (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stopMode,
  input wire logic debugMode,
  input wire logic systemResetReq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [4:0] hiCnt_q;

  // =====================================================
  // length of the reset request so far
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) hiCnt_q <= 5'h00;
    else hiCnt_q <= systemResetReq ? hiCnt_q + 5'h01 : 5'h00;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  pulse_len_a: assert property ($fell(systemResetReq) |-> hiCnt_q == 5'h10)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (hiCnt_q <= 5'h10)
    else $error("reset pulse too long");
  hold_modes_a: assert property (
    $rose(systemResetReq) |-> !$past(debugMode) && !$past(stopMode))
    else $error("overflow while held");
  bresp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write response late");
  rresp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  busy_wr_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  busy_rd_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");

  cover property ($rose(systemResetReq));
  cover property (debugMode && s_axi_bvalid);
  cover property (stopMode && s_axi_rvalid);
endmodule

bind wdg_top wdg_monitor u_mon (
  .clk_sys(clk_sys), .resetn(resetn), .stopMode(stopMode), .debugMode(debugMode),
  .systemResetReq(systemResetReq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
